// File: design/dbs_pkg.sv
// Constants, types and sequence table for the display bias fault supervisor.
// Assumes one 25 MHz core clock; analog detectors deliver synchronous levels.
package dbs_pkg;

    // Core clock
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;

    // Times as specified, in their own units
    localparam int unsigned EN_FILT_US = 10;
    localparam int unsigned QUAL_US = 10;
    localparam int unsigned RESET_LOW_MS = 1;
    localparam int unsigned POWERUP_MS = 1;
    localparam int unsigned COMMON_ELECTRODE_OUT_FILT_MS = 60;
    localparam int unsigned RETRY_MS = 1900;
    localparam int unsigned SEQ_STEP_MS = 1;
    localparam int unsigned FLT_PIN_HZ = 1000;

    // Derived cycle counts
    localparam int unsigned EN_FILT_CYC = EN_FILT_US * CLK_MHZ;
    localparam int unsigned QUAL_CYC = QUAL_US * CLK_MHZ;
    localparam int unsigned RESET_LOW_CYC = RESET_LOW_MS * CLK_KHZ;
    localparam int unsigned POWERUP_CYC = POWERUP_MS * CLK_KHZ;
    localparam int unsigned COMMON_ELECTRODE_OUT_FILT_CYC = COMMON_ELECTRODE_OUT_FILT_MS * CLK_KHZ;
    localparam int unsigned RETRY_CYC = RETRY_MS * CLK_KHZ;
    localparam int unsigned SEQ_STEP_CYC = SEQ_STEP_MS * CLK_KHZ;
    localparam int unsigned FLT_PERIOD_CYC = CLK_KHZ * 1000 / FLT_PIN_HZ;

    // Fault pin low-time share, percent
    localparam int unsigned DUTY_GATE_PCT = 75;
    localparam int unsigned DUTY_SRC_PCT = 50;
    localparam int unsigned DUTY_COMMON_ELECTRODE_OUT_PCT = 25;

    // Field codes
    localparam logic [1:0] TFAULT_CODE_NOM = 2'h2;
    localparam logic [2:0] SEQ_DEFAULT = 3'h2;
    localparam int unsigned SEQ_STEPS = 4;

    // Rail enables, one bit per output
    typedef struct packed {
        logic avdd;
        logic neg_source_rail;
        logic vgoff;
        logic vgon;
        logic common_electrode_out;
    } dbs_rails_t;

    // Raw short/overload comparator levels
    typedef struct packed {
        logic boost;
        logic avdd;
        logic neg_source_rail;
        logic vgon;
        logic vgoff;
    } dbs_short_t;

    typedef enum logic [1:0] {
        FC_NONE = 2'h0,
        FC_GATE = 2'h1,
        FC_SRC = 2'h2,
        FC_COMMON_ELECTRODE_OUT = 2'h3
    } dbs_fclass_t;

    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_POWERUP = 6'h02,
        ST_WAIT_START = 6'h04,
        ST_SEQ = 6'h08,
        ST_RUN = 6'h10,
        ST_RETRY = 6'h20
    } dbs_state_t;

    // Rails switched on at a given step of a sequence code
    function automatic dbs_rails_t dbs_seq_step(input logic [2:0] code, input logic [1:0] step);
        logic [19:0] t;
        t = 20'h0;
        case (code)
            3'h0: t = {5'h10, 5'h08, 5'h04, 5'h03};
            3'h1: t = {5'h10, 5'h08, 5'h02, 5'h05};
            3'h3: t = {5'h08, 5'h10, 5'h02, 5'h05};
            3'h4: t = {5'h08, 5'h04, 5'h10, 5'h03};
            3'h5: t = {5'h04, 5'h02, 5'h08, 5'h11};
            3'h6: t = {5'h18, 5'h04, 5'h03, 5'h00};
            default: t = {5'h08, 5'h10, 5'h04, 5'h03};
        endcase
        dbs_seq_step = t[5'(19 - 5 * step) -: 5];
    endfunction : dbs_seq_step

endpackage : dbs_pkg

// File: design/dbs_supervisor.sv
// Digital supervisor of a five-rail display bias supply: enable handling,
// start-up sequencing, fault qualification, retry and the fault pin.
// Assumes all inputs synchronous to CORE_CLK_I; pin wire resolved outside.
//
// What this block does
// R1 - Standalone: gate rail fault toggles fault pin at 1 kHz, 75 percent.
// R2 - Standalone: source rails or boost fault gives 50 percent pulse train.
// R3 - Standalone: common-electrode fault gives 25 percent pulse train.
// R4 - Common-electrode deviation reported after filter time, 60 ms at code 10.
// R5 - Retry start-up 1.9 s after fault shutdown when retry code is 10 or 11.
// R6 - Short or overload counts as fault only after 10 us persistence.
// R7 - Controller holds enable low at least 1 ms to reset the device.
// R8 - Enable low keeps shutdown; enable high makes the device active.
// R9 - Standalone: enable rise switches outputs on in stored sequence order.
// R10 - Address pin unconnected selects standalone operation without bus.
// R11 - Address pin at ground or regulator level selects bus address.
// R12 - Bus mode: fault pin low while status waits to be read.
// R13 - Pump supply switch closed only while positive charge pump enabled.
// R14 - Enable high starts core regulator; functional after 1 ms delay.
// R15 - Base variant with address tied: outputs start on start bit only.
// R16 - Regulator out of range sets status bit and pulls fault pin in bus mode.
// R17 - Standalone without fault keeps fault pin released.
// R18 - Several faults: one class shown, gate rails first.
module dbs_supervisor
    import dbs_pkg::*;
#(
    parameter int unsigned RESET_LOW_CYCLES = dbs_pkg::RESET_LOW_CYC,
    parameter int unsigned POWERUP_CYCLES = dbs_pkg::POWERUP_CYC,
    parameter int unsigned COMMON_ELECTRODE_OUT_FILT_CYCLES = dbs_pkg::COMMON_ELECTRODE_OUT_FILT_CYC,
    parameter int unsigned COMMON_ELECTRODE_OUT_FILT_ALT_CYCLES = dbs_pkg::COMMON_ELECTRODE_OUT_FILT_CYC,
    parameter int unsigned RETRY_CYCLES = dbs_pkg::RETRY_CYC,
    parameter int unsigned RETRY_ALT_CYCLES = dbs_pkg::RETRY_CYC,
    parameter int unsigned SEQ_STEP_CYCLES = dbs_pkg::SEQ_STEP_CYC,
    parameter int unsigned FLT_PERIOD_CYCLES = dbs_pkg::FLT_PERIOD_CYC
)
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    // Enable and address pins
    input wire logic ENABLE_I,
    input wire logic ADDR_FLOAT_I,
    input wire logic ADDR_HIGH_I,
    // Configuration from stored settings and bus
    input wire logic BASE_VARIANT_I,
    input wire logic START_BIT_I,
    input wire logic [2:0] SEQ_SET_I,
    input wire logic [1:0] TFAULT_I,
    input wire logic [1:0] TRETRY_I,
    input wire logic STATUS_PENDING_I,
    // Analog detectors
    input wire dbs_pkg::dbs_short_t SHORT_I,
    input wire logic COMMON_ELECTRODE_OUT_DEV_I,
    input wire logic CORE_REG_OOR_DET_I,
    input wire logic CORE_REG_OOR_CLR_I,
    // Rail and regulator control
    output logic CORE_REG_EN_O,
    output dbs_pkg::dbs_rails_t RAILS_O,
    output logic PUMP_SWITCH_O,
    // Mode and status
    output logic FUNCTIONAL_O,
    output logic BUS_MODE_O,
    output logic BUS_ADDR_HIGH_O,
    output logic CORE_REG_OUT_OF_RANGE_O,
    output dbs_pkg::dbs_fclass_t FAULT_CLASS_O,
    // Open-drain fault pin
    output logic FAULT_OUT_N_O,
    output logic FAULT_OUT_N_OE_O
);
    import dbs_pkg::*;

    localparam int unsigned TW = 26;
    localparam int unsigned EW = 8;
    localparam int unsigned RW = 16;
    localparam int unsigned PW = 16;

    dbs_state_t state_r;
    dbs_state_t state_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic [1:0] step_r;
    logic [1:0] step_nxt;
    dbs_rails_t rails_r;
    dbs_rails_t rails_nxt;
    dbs_fclass_t fclass_r;
    dbs_fclass_t fclass_nxt;

    logic en_filt_r;
    logic [EW-1:0] en_cnt_r;
    logic [RW-1:0] low_cnt_r;
    logic dev_reset;
    logic bus_mode_r;
    logic addr_high_r;
    logic oor_r;

    dbs_short_t short_q;
    logic [TW-1:0] common_electrode_out_cnt_r;
    logic common_electrode_out_q;
    logic [TW-1:0] common_electrode_out_lim;
    logic [TW-1:0] retry_lim;
    dbs_fclass_t fault_now;

    logic [PW-1:0] pcnt_r;
    logic [PW-1:0] low_cyc;
    logic drive_low;

    // Enable glitch filter: level accepted only after it has held steady
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            en_filt_r <= 1'b0;
            en_cnt_r <= '0;
        end
        else if (ENABLE_I == en_filt_r)
        begin
            en_cnt_r <= '0;
        end
        else if (en_cnt_r >= EW'(EN_FILT_CYC - 1))
        begin
            en_filt_r <= ENABLE_I; // [R8]
            en_cnt_r <= '0;
        end
        else
        begin
            en_cnt_r <= en_cnt_r + 1'b1;
        end
    end

    // Enable held low long enough resets latched status
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            low_cnt_r <= '0;
        end
        else if (ENABLE_I)
        begin
            low_cnt_r <= '0;
        end
        else if (low_cnt_r < RW'(RESET_LOW_CYCLES))
        begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end
    assign dev_reset = (low_cnt_r >= RW'(RESET_LOW_CYCLES - 1)); // [R7]

    // Short/overload qualification, one counter per comparator level (boost included)
    for (genvar g = 0; g < $bits(dbs_short_t); g++)
    begin : g_qual
        logic [EW-1:0] cnt_r;
        always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
        begin
            if (!RESET_N_I)
            begin
                cnt_r <= '0;
            end
            else if (!SHORT_I[g])
            begin
                cnt_r <= '0;
            end
            else if (cnt_r < EW'(QUAL_CYC - 1))
            begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
        assign short_q[g] = SHORT_I[g] && (cnt_r >= EW'(QUAL_CYC - 1)); // [R6]
    end

    // Common-electrode deviation filter; only one code's time is known
    assign common_electrode_out_lim = (TFAULT_I == TFAULT_CODE_NOM) ? TW'(COMMON_ELECTRODE_OUT_FILT_CYCLES - 1) : TW'(COMMON_ELECTRODE_OUT_FILT_ALT_CYCLES - 1);
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            common_electrode_out_cnt_r <= '0;
        end
        else if (!COMMON_ELECTRODE_OUT_DEV_I)
        begin
            common_electrode_out_cnt_r <= '0;
        end
        else if (common_electrode_out_cnt_r < common_electrode_out_lim)
        begin
            common_electrode_out_cnt_r <= common_electrode_out_cnt_r + 1'b1;
        end
    end
    assign common_electrode_out_q = COMMON_ELECTRODE_OUT_DEV_I && (common_electrode_out_cnt_r >= common_electrode_out_lim) && rails_r.common_electrode_out; // [R4]

    // Fixed priority when several classes coincide
    always_comb
    begin
        if (short_q.vgon || short_q.vgoff)
            fault_now = FC_GATE; // [R18]
        else if (short_q.avdd || short_q.neg_source_rail || short_q.boost)
            fault_now = FC_SRC;
        else if (common_electrode_out_q)
            fault_now = FC_COMMON_ELECTRODE_OUT;
        else
            fault_now = FC_NONE;
    end

    assign retry_lim = TRETRY_I[1] ? TW'(RETRY_CYCLES - 1) : TW'(RETRY_ALT_CYCLES - 1);

    // Power state machine
    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt = tmr_r + 1'b1;
        step_nxt = step_r;
        rails_nxt = rails_r;
        fclass_nxt = fclass_r;
        case (state_r)
            ST_OFF:
            begin
                tmr_nxt = '0;
                rails_nxt = '0;
                fclass_nxt = FC_NONE;
                if (en_filt_r)
                    state_nxt = ST_POWERUP; // [R8]
            end
            ST_POWERUP:
            begin
                if (tmr_r >= TW'(POWERUP_CYCLES - 1))
                begin
                    tmr_nxt = '0;
                    step_nxt = '0;
                    if (!ADDR_FLOAT_I && BASE_VARIANT_I)
                        state_nxt = ST_WAIT_START; // [R15]
                    else
                        state_nxt = ST_SEQ; // [R9] [R14]
                end
            end
            ST_WAIT_START:
            begin
                tmr_nxt = '0;
                if (START_BIT_I)
                    state_nxt = ST_SEQ; // [R15]
            end
            ST_SEQ:
            begin
                if (tmr_r == '0)
                    rails_nxt = rails_r | dbs_seq_step(SEQ_SET_I, step_r); // [R9]
                if (tmr_r >= TW'(SEQ_STEP_CYCLES - 1) || step_r == 2'(SEQ_STEPS - 1))
                begin
                    tmr_nxt = '0;
                    step_nxt = step_r + 1'b1;
                    if (step_r == 2'(SEQ_STEPS - 1))
                        state_nxt = ST_RUN;
                end
            end
            ST_RUN:
            begin
                tmr_nxt = '0;
            end
            ST_RETRY:
            begin
                rails_nxt = '0;
                if (tmr_r >= retry_lim)
                begin
                    tmr_nxt = '0;
                    step_nxt = '0;
                    fclass_nxt = FC_NONE;
                    state_nxt = ST_SEQ; // [R5]
                end
            end
            default:
            begin
                state_nxt = ST_OFF;
                rails_nxt = '0;
            end
        endcase
        if ((state_r == ST_SEQ || state_r == ST_RUN) && fault_now != FC_NONE)
        begin
            rails_nxt = '0;
            fclass_nxt = fault_now;
            tmr_nxt = '0;
            state_nxt = ST_RETRY; // [R5]
        end
        if (!en_filt_r)
        begin
            rails_nxt = '0;
            fclass_nxt = FC_NONE;
            state_nxt = ST_OFF; // [R8]
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_r <= ST_OFF;
            tmr_r <= '0;
            step_r <= '0;
            rails_r <= '0;
            fclass_r <= FC_NONE;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            step_r <= step_nxt;
            rails_r <= rails_nxt;
            fclass_r <= fclass_nxt;
        end
    end

    // Address pin read once at the end of power-up; later changes ignored
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            bus_mode_r <= 1'b0;
            addr_high_r <= 1'b0;
        end
        else if (state_r == ST_OFF)
        begin
            bus_mode_r <= 1'b0;
        end
        else if (state_r == ST_POWERUP && state_nxt != ST_POWERUP)
        begin
            bus_mode_r <= !ADDR_FLOAT_I; // [R10]
            addr_high_r <= ADDR_HIGH_I; // [R11]
        end
    end

    // Regulator range flag: detection wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            oor_r <= 1'b0;
        else if (CORE_REG_OOR_DET_I && state_r != ST_OFF)
            oor_r <= 1'b1; // [R16]
        else if (CORE_REG_OOR_CLR_I || dev_reset)
            oor_r <= 1'b0;
    end

    // 1 kHz pulse code, restarting whenever no fault is shown
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            pcnt_r <= '0;
        else if (fclass_r == FC_NONE || pcnt_r >= PW'(FLT_PERIOD_CYCLES - 1))
            pcnt_r <= '0;
        else
            pcnt_r <= pcnt_r + 1'b1;
    end

    always_comb
    begin
        case (fclass_r)
            FC_GATE: low_cyc = PW'(FLT_PERIOD_CYCLES * DUTY_GATE_PCT / 100); // [R1]
            FC_SRC: low_cyc = PW'(FLT_PERIOD_CYCLES * DUTY_SRC_PCT / 100); // [R2]
            FC_COMMON_ELECTRODE_OUT: low_cyc = PW'(FLT_PERIOD_CYCLES * DUTY_COMMON_ELECTRODE_OUT_PCT / 100); // [R3]
            default: low_cyc = '0; // [R17]
        endcase
    end

    always_comb
    begin
        if (bus_mode_r)
            drive_low = STATUS_PENDING_I || oor_r; // [R12] [R16]
        else
            drive_low = (pcnt_r < low_cyc) && (fclass_r != FC_NONE); // [R1] [R17]
    end

    // Registered outputs
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            CORE_REG_EN_O <= 1'b0;
            RAILS_O <= '0;
            PUMP_SWITCH_O <= 1'b0;
            FUNCTIONAL_O <= 1'b0;
            BUS_MODE_O <= 1'b0;
            BUS_ADDR_HIGH_O <= 1'b0;
            CORE_REG_OUT_OF_RANGE_O <= 1'b0;
            FAULT_CLASS_O <= FC_NONE;
            FAULT_OUT_N_O <= 1'b1;
            FAULT_OUT_N_OE_O <= 1'b0;
        end
        else
        begin
            CORE_REG_EN_O <= (state_nxt != ST_OFF); // [R14]
            RAILS_O <= rails_nxt;
            PUMP_SWITCH_O <= rails_nxt.vgon; // [R13]
            FUNCTIONAL_O <= (state_r != ST_OFF) && (state_r != ST_POWERUP);
            BUS_MODE_O <= bus_mode_r;
            BUS_ADDR_HIGH_O <= addr_high_r;
            CORE_REG_OUT_OF_RANGE_O <= oor_r;
            FAULT_CLASS_O <= fclass_r;
            FAULT_OUT_N_O <= !drive_low;
            FAULT_OUT_N_OE_O <= drive_low;
        end
    end

endmodule : dbs_supervisor

// File: verification/dbs_supervisor_checker.sv
// Port assertions for the display bias fault supervisor.
// Assumes one core clock with async active-low reset; attached by bind.
module dbs_supervisor_checker
    import dbs_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = 20,
    parameter int unsigned COMMON_ELECTRODE_OUT_FILT_CYCLES = 100,
    parameter int unsigned RETRY_CYCLES = 200
)
(
    // Clock, reset and inputs
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic ENABLE_I,
    input wire logic STATUS_PENDING_I,
    input wire logic COMMON_ELECTRODE_OUT_DEV_I,
    // Outputs
    input wire logic CORE_REG_EN_O,
    input wire dbs_pkg::dbs_rails_t RAILS_O,
    input wire logic PUMP_SWITCH_O,
    input wire logic FUNCTIONAL_O,
    input wire logic BUS_MODE_O,
    input wire logic CORE_REG_OUT_OF_RANGE_O,
    input wire dbs_pkg::dbs_fclass_t FAULT_CLASS_O,
    input wire logic FAULT_OUT_N_OE_O
);
    logic [15:0] en_hi_r, en_lo_r, reg_on_r, vd_r, flt_r;

    function automatic logic [15:0] run(input logic [15:0] c, input logic h);
        run = h ? c + 16'(c != 16'hffff) : 16'h0;
    endfunction : run

    // Saturating run lengths, so long waits need no long repetitions
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            en_hi_r <= '0;
            en_lo_r <= '0;
            reg_on_r <= '0;
            vd_r <= '0;
            flt_r <= '0;
        end
        else
        begin
            en_hi_r <= run(en_hi_r, ENABLE_I);
            en_lo_r <= run(en_lo_r, !ENABLE_I);
            reg_on_r <= run(reg_on_r, CORE_REG_EN_O);
            vd_r <= run(vd_r, COMMON_ELECTRODE_OUT_DEV_I);
            flt_r <= run(flt_r, FAULT_CLASS_O != FC_NONE);
        end
    end

    default clocking dc @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    a_pump_tracks_gate: assert property (PUMP_SWITCH_O == RAILS_O.vgon)
        else $error("pump switch differs from gate rail");
    a_off_when_disabled: assert property (en_lo_r > 16'd253 |-> !CORE_REG_EN_O && RAILS_O == '0)
        else $error("outputs on while disabled");
    a_enable_filtered: assert property ($rose(CORE_REG_EN_O) |-> en_hi_r >= 249 && en_hi_r <= 254)
        else $error("regulator start not after enable filter");
    a_powerup_delay: assert property ($rose(FUNCTIONAL_O) |-> reg_on_r >= POWERUP_CYCLES - 1
        && reg_on_r <= POWERUP_CYCLES + 2)
        else $error("functional not after power-up delay");
    a_quiet_idle: assert property ((!BUS_MODE_O && FAULT_CLASS_O == FC_NONE)[*3]
        |-> !$past(FAULT_OUT_N_OE_O))
        else $error("fault pin driven without fault");
    a_bus_pin: assert property (BUS_MODE_O [*2]
        |-> FAULT_OUT_N_OE_O == ($past(STATUS_PENDING_I) || CORE_REG_OUT_OF_RANGE_O))
        else $error("bus fault pin wrong");
    a_fault_all_off: assert property ($rose(FAULT_CLASS_O != FC_NONE) |-> ##[0:1] (RAILS_O == '0) [*8])
        else $error("rails on after fault");
    a_common_electrode_out_filter: assert property ($rose(FAULT_CLASS_O == FC_COMMON_ELECTRODE_OUT) |-> vd_r >= COMMON_ELECTRODE_OUT_FILT_CYCLES)
        else $error("common electrode fault too early");
    a_retry_wait: assert property ($fell(FAULT_CLASS_O != FC_NONE)
        |-> flt_r >= RETRY_CYCLES && flt_r <= RETRY_CYCLES + 3)
        else $error("retry wait length wrong");
endmodule : dbs_supervisor_checker

bind dbs_supervisor dbs_supervisor_checker #(.POWERUP_CYCLES(POWERUP_CYCLES), .COMMON_ELECTRODE_OUT_FILT_CYCLES(COMMON_ELECTRODE_OUT_FILT_CYCLES),
    .RETRY_CYCLES(RETRY_CYCLES)) dbs_supervisor_checker_i (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
    .ENABLE_I(ENABLE_I), .STATUS_PENDING_I(STATUS_PENDING_I), .COMMON_ELECTRODE_OUT_DEV_I(COMMON_ELECTRODE_OUT_DEV_I),
    .CORE_REG_EN_O(CORE_REG_EN_O), .RAILS_O(RAILS_O), .PUMP_SWITCH_O(PUMP_SWITCH_O), .FUNCTIONAL_O(FUNCTIONAL_O),
    .BUS_MODE_O(BUS_MODE_O), .CORE_REG_OUT_OF_RANGE_O(CORE_REG_OUT_OF_RANGE_O), .FAULT_CLASS_O(FAULT_CLASS_O),
    .FAULT_OUT_N_OE_O(FAULT_OUT_N_OE_O));

// File: verification/dbs_host_model.sv
// Behavioural two-wire host: posts status, reads it when the fault pin asks.
// Assumes the resolved pin level (pulled up), sampled on the core clock.
module dbs_host_model #(
    parameter int unsigned READ_DLY = 8
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic post_i,
    input wire logic pin_i,
    output logic pending_o,
    output logic clr_o
);
    int unsigned low_cnt_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pending_o <= 1'b0;
            clr_o <= 1'b0;
            low_cnt_r <= 0;
        end
        else
        begin
            clr_o <= 1'b0;
            low_cnt_r <= pin_i ? 0 : low_cnt_r + 1;
            if (post_i)
                pending_o <= 1'b1;
            // Slow reader: fetches status only after the pin stayed low a while
            if (low_cnt_r == READ_DLY)
            begin
                pending_o <= 1'b0;
                clr_o <= 1'b1;
            end
        end
    end
endmodule : dbs_host_model

// File: verification/dbs_supervisor_test.sv
// Self-checking bench of the fault supervisor with a behavioural bus host.
// Assumes shortened timing parameters; the checker comes in by bind.
module dbs_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dbs_pkg::*;

    logic clk, rst_n, en, afl, ahi, base, start, vdev, oor_det, post, pin;
    logic [1:0] tf, tr;
    logic pend, clr, reg_en, pump, func, bus, bus_hi, oor, fo, foe;
    logic [2:0] seq;
    dbs_short_t sh;
    dbs_rails_t rails;
    dbs_fclass_t fcls;
    int miscompares, n_tests;
    logic [4:0] cum [7][4] = '{'{5'h10, 5'h18, 5'h1c, 5'h1f}, '{5'h10, 5'h18, 5'h1a, 5'h1f},
        '{5'h08, 5'h18, 5'h1c, 5'h1f}, '{5'h08, 5'h18, 5'h1a, 5'h1f}, '{5'h08, 5'h0c, 5'h1c, 5'h1f},
        '{5'h04, 5'h06, 5'h0e, 5'h1f}, '{5'h18, 5'h1c, 5'h1f, 5'h1f}};

    // Unknown filter code keeps its full-length default, so a short deviation must stay unreported
    dbs_supervisor #(.POWERUP_CYCLES(20), .COMMON_ELECTRODE_OUT_FILT_CYCLES(100), .RETRY_CYCLES(200), .SEQ_STEP_CYCLES(10),
        .FLT_PERIOD_CYCLES(100)) dbs_supervisor_i (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .ENABLE_I(en), .ADDR_FLOAT_I(afl), .ADDR_HIGH_I(ahi),
        .BASE_VARIANT_I(base), .START_BIT_I(start), .SEQ_SET_I(seq), .TFAULT_I(tf), .TRETRY_I(tr),
        .STATUS_PENDING_I(pend), .SHORT_I(sh), .COMMON_ELECTRODE_OUT_DEV_I(vdev), .CORE_REG_OOR_DET_I(oor_det),
        .CORE_REG_OOR_CLR_I(clr), .CORE_REG_EN_O(reg_en), .RAILS_O(rails), .PUMP_SWITCH_O(pump),
        .FUNCTIONAL_O(func), .BUS_MODE_O(bus), .BUS_ADDR_HIGH_O(bus_hi), .CORE_REG_OUT_OF_RANGE_O(oor),
        .FAULT_CLASS_O(fcls), .FAULT_OUT_N_O(fo), .FAULT_OUT_N_OE_O(foe));

    dbs_host_model dbs_host_model_i (.clk_i(clk), .rst_n_i(rst_n), .post_i(post), .pin_i(pin), .pending_o(pend),
        .clr_o(clr));

    // Open-drain pin with its pull-up
    assign pin = foe ? fo : 1'b1;

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic power(input logic [2:0] code, input logic fl, input logic b);
        @(posedge clk);
        en <= 1'b0;
        repeat (300) @(posedge clk);
        seq <= code;
        afl <= fl;
        base <= b;
        start <= 1'b0;
        en <= 1'b1;
        repeat (240) @(negedge clk);
        check(8'(reg_en), 8'h0);
    endtask : power

    task automatic seq_test;
        logic [4:0] prev;
        int i;
        for (int c = 0; c < 7; c++)
        begin
            power(3'(c), 1'b1, 1'b0);
            for (i = 0; i < 100 && rails === 5'h0; i++) @(negedge clk);
            check(8'(bus), 8'h0);
            check(8'(func), 8'h1);
            for (int k = 0; k < 4; k++)
            begin
                for (i = 0; k > 0 && i < 15 && rails === prev; i++) @(negedge clk);
                check(8'(rails), 8'(cum[c][k]));
                prev = rails;
                if (rails === 5'h1f)
                    break;
            end
        end
    endtask : seq_test

    task automatic fault_case(input logic [4:0] s, input logic v, input dbs_fclass_t c, input int low);
        int i;
        int n;
        check(8'(foe), 8'h0);
        @(posedge clk);
        sh <= dbs_short_t'(s);
        vdev <= v;
        for (i = 0; i < 400 && fcls === FC_NONE; i++) @(negedge clk);
        check(8'(fcls), 8'(c));
        check(8'(rails), 8'h0);
        @(posedge clk);
        sh <= '0;
        vdev <= 1'b0;
        n = 0;
        for (i = 0; i < 100; i++)
        begin
            @(negedge clk);
            n += int'(foe === 1'b1);
        end
        check(8'(n), 8'(low));
        for (i = 101; i < 400 && rails === 5'h0; i++) @(negedge clk);
        check(8'(i >= 200 && i < 215), 8'h1);
        for (i = 0; i < 60 && rails !== 5'h1f; i++) @(negedge clk);
    endtask : fault_case

    task automatic fault_test;
        power(3'h2, 1'b1, 1'b0);
        repeat (120) @(negedge clk);
        fault_case(5'h02, 1'b0, FC_GATE, 75);
        fault_case(5'h01, 1'b0, FC_GATE, 75);
        @(posedge clk);
        tr <= 2'h3;
        @(negedge clk);
        fault_case(5'h10, 1'b0, FC_SRC, 50);
        fault_case(5'h08, 1'b0, FC_SRC, 50);
        fault_case(5'h04, 1'b0, FC_SRC, 50);
        fault_case(5'h00, 1'b1, FC_COMMON_ELECTRODE_OUT, 25);
        fault_case(5'h0a, 1'b0, FC_GATE, 75);
        // Overload shorter than the qualification time, deviation under an unknown filter code
        @(posedge clk);
        sh <= dbs_short_t'(5'h08);
        vdev <= 1'b1;
        tf <= 2'h0;
        repeat (200) @(posedge clk);
        sh <= '0;
        vdev <= 1'b0;
        tf <= 2'h2;
        repeat (5) @(negedge clk);
        check(8'(fcls), 8'h0);
        check(8'(rails), 8'h1f);
    endtask : fault_test

    task automatic bus_test;
        int i;
        power(3'h2, 1'b0, 1'b1);
        for (i = 0; i < 100 && func !== 1'b1; i++) @(negedge clk);
        repeat (50) @(negedge clk);
        check(8'(rails), 8'h0);
        check(8'({bus, bus_hi}), 8'h3);
        check(8'(pin), 8'h1);
        @(posedge clk);
        start <= 1'b1;
        for (i = 0; i < 100 && rails !== 5'h1f; i++) @(negedge clk);
        check(8'(rails), 8'h1f);
        @(posedge clk);
        post <= 1'b1;
        @(posedge clk);
        post <= 1'b0;
        repeat (3) @(negedge clk);
        check(8'(pin), 8'h0);
        for (i = 0; i < 40 && pin !== 1'b1; i++) @(negedge clk);
        check(8'(pin), 8'h1);
        @(posedge clk);
        oor_det <= 1'b1;
        @(posedge clk);
        oor_det <= 1'b0;
        repeat (3) @(negedge clk);
        check(8'({oor, pin, rails}), 8'h5f);
        for (i = 0; i < 40 && pin !== 1'b1; i++) @(negedge clk);
        check(8'({oor, pin}), 8'h1);
        @(posedge clk);
        ahi <= 1'b0;
        power(3'h2, 1'b0, 1'b0);
        for (i = 0; i < 100 && rails !== 5'h1f; i++) @(negedge clk);
        check(8'({bus, bus_hi, rails}), 8'h5f);
    endtask : bus_test

    initial
    begin
        rst_n = 1'b0;
        en = 1'b0;
        afl = 1'b1;
        ahi = 1'b1;
        tf = 2'h2;
        tr = 2'h2;
        base = 1'b0;
        start = 1'b0;
        seq = 3'h2;
        sh = '0;
        vdev = 1'b0;
        oor_det = 1'b0;
        post = 1'b0;
        miscompares = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        seq_test();
        fault_test();
        bus_test();
        finish_test();
    end

    // Whole run needs about 9000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule : dbs_supervisor_test
